// ---- hw/sstx_top.sv ----
// Purpose: Transmit side of a synchronous serial channel with queue and status
// Assumes: Avalon-MM slave, one wait state; RX status comes from neighbour logic
// Notes:   Data leaves LSB first, changing on falling shift clock edges
`timescale 1ns/1ps
module sstx_top (
	input  wire logic        CLK,
	input  wire logic        RESETN,
	input  wire logic [2:0]  AVS_ADDRESS,
	input  wire logic        AVS_READ,
	input  wire logic        AVS_WRITE,
	input  wire logic [31:0] AVS_WRITEDATA,
	output logic [31:0]      AVS_READDATA,
	output logic             AVS_WAITREQUEST,
	input  wire logic        SHIFT_CLOCK_PIN_IN,
	output logic             SHIFT_CLOCK_PIN_OUT,
	output logic             SHIFT_CLOCK_PIN_OE,
	output logic             SERIAL_OUT_PIN,
	input  wire logic [2:0]  RX_OCCUPANCY,
	input  wire logic        RX_OVERRUN_EVENT,
	input  wire logic [7:0]  RX_DATA,
	output logic             RX_DATA_READ,
	output logic             TRANSMIT_INTERRUPT,
	output logic             UNDERRUN_EVENT,
	output logic             IRQ
);
	////////////////////////////////////////////////////////////////////////////
	// Bus slave
	logic               ack;
	sstx_pkg::sstx_mode_t  mode;
	sstx_pkg::sstx_txcfg_t txcfg;
	logic               hold_empty;
	logic               rx_overrun;
	logic               tx_underrun;
	logic [2:0]         irq_status;
	logic [2:0]         irq_mask;
	logic [31:0]        read_word;

	wire req       = AVS_READ | AVS_WRITE;
	wire wr_go     = AVS_WRITE & ack;
	wire rd_go     = AVS_READ & ack;
	wire sel_data  = AVS_ADDRESS == sstx_pkg::OFS_DATA;
	wire sel_mode  = AVS_ADDRESS == sstx_pkg::OFS_MODE;
	wire sel_txcfg = AVS_ADDRESS == sstx_pkg::OFS_TXCFG;
	wire sel_rxst  = AVS_ADDRESS == sstx_pkg::OFS_RXST;
	wire sel_txst  = AVS_ADDRESS == sstx_pkg::OFS_TXST;
	wire sel_ists  = AVS_ADDRESS == sstx_pkg::OFS_IRQ_STATUS;
	wire sel_imask = AVS_ADDRESS == sstx_pkg::OFS_IRQ_MASK;
	wire data_wr   = wr_go & sel_data;
	wire data_rd   = rd_go & sel_data;

	assign AVS_WAITREQUEST = req & ~ack;
	assign RX_DATA_READ    = data_rd;

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN)
			ack <= 1'b0;
		else
			ack <= req & ~ack;
	end

	////////////////////////////////////////////////////////////////////////////
	// Transmit queue
	logic [7:0] q_rdata;
	logic [2:0] q_level;
	logic       q_empty;
	logic       q_full;
	logic       pop;

	wire full_dpx = mode.duplex == sstx_pkg::DUPLEX_FULL;
	wire dbuf     = mode.double_buffer | mode.queue_enable;
	wire q_clear  = wr_go & sel_txcfg & AVS_WRITEDATA[sstx_pkg::TXCFG_CLEAR_BIT];
	wire q_push   = data_wr;
	wire can_pop  = ~q_empty;
	// Without the queue the holding store is a single byte
	wire [2:0] q_cap = ~mode.queue_enable ? sstx_pkg::CAP_SINGLE
		: full_dpx ? sstx_pkg::CAP_FULL_DPX : sstx_pkg::CAP_HALF_DPX;

	sstx_queue u_queue (
		.clk    (CLK),
		.resetn (RESETN),
		.push   (q_push),
		.pop    (pop),
		.clear  (q_clear),
		.cap    (q_cap),
		.wdata  (AVS_WRITEDATA[7:0]),
		.rdata  (q_rdata),
		.level  (q_level),
		.empty  (q_empty),
		.full   (q_full)
	);

	////////////////////////////////////////////////////////////////////////////
	// Shift clock: synchronised pin or local divider
	logic sclk_s;
	logic sclk_d;
	logic sclk_o;
	logic [3:0] half_cnt;
	sstx_pkg::sstx_state_t state;
	logic [7:0] shreg;
	logic       loaded;
	logic [2:0] bit_cnt;

	sstx_sync u_sclk_sync (
		.clk    (CLK),
		.resetn (RESETN),
		.din    (SHIFT_CLOCK_PIN_IN),
		.dout   (sclk_s)
	);

	wire idle     = state == sstx_pkg::ST_IDLE;
	wire ext_fall = ~mode.clock_out & ~sclk_s & sclk_d;
	wire ext_rise = ~mode.clock_out & sclk_s & ~sclk_d;
	wire tick     = ~idle & mode.clock_out & (half_cnt == 4'h0);
	wire fall     = ~idle & (mode.clock_out ? tick & sclk_o : ext_fall);
	wire rise     = ~idle & (mode.clock_out ? tick & ~sclk_o : ext_rise);

	assign SHIFT_CLOCK_PIN_OUT = sclk_o;
	assign SHIFT_CLOCK_PIN_OE  = mode.clock_out;

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN)
			sclk_d <= 1'b1;
		else
			sclk_d <= sclk_s;
	end

	// Clock idles high and only runs while a frame is in flight
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			sclk_o   <= 1'b1;
			half_cnt <= 4'h0;
		end else begin
			sclk_o   <= idle ? 1'b1 : sclk_o ^ tick;
			half_cnt <= (idle | tick) ? sstx_pkg::SHIFT_HALF_CYCLES - 4'h1
				: half_cnt - 4'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Frame sequencing
	wire start_out  = mode.clock_out & idle & (loaded | can_pop);
	wire start_in   = ~mode.clock_out & idle & ext_fall;
	wire start      = start_out | start_in;
	wire need_fetch = start & ~loaded;
	wire frame_done = rise & (bit_cnt == sstx_pkg::LAST_BIT);
	wire refill     = frame_done & dbuf & can_pop;
	// Preload while idle so the byte is ready before the first clock edge
	wire early_move = dbuf & idle & ~loaded & can_pop & ~start;
	wire underrun   = start_in & ~loaded & ~can_pop;
	wire move_evt   = pop & dbuf;
	wire tx_evt     = dbuf ? move_evt : frame_done;
	wire keep_going = refill & mode.clock_out;
	wire [7:0] frame_byte = loaded ? shreg
		: can_pop ? q_rdata : sstx_pkg::DUMMY_BYTE;

	assign pop = (need_fetch & can_pop) | refill | early_move;

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN)
			state <= sstx_pkg::ST_IDLE;
		else begin
			case (state)
				sstx_pkg::ST_IDLE: begin
					if (start)
						state <= sstx_pkg::ST_SHIFT;
				end
				sstx_pkg::ST_SHIFT: begin
					// Nothing waiting ends the frame and parks the clock
					if (frame_done & ~keep_going)
						state <= sstx_pkg::ST_IDLE;
				end
				default: state <= sstx_pkg::ST_IDLE;
			endcase
		end
	end

	// Counter runs even for the dummy frame after an underrun
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN)
			bit_cnt <= 3'h0;
		else if (start)
			bit_cnt <= 3'h0;
		else if (rise)
			bit_cnt <= bit_cnt + 3'h1;
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN)
			loaded <= 1'b0;
		else if (early_move | (refill & ~mode.clock_out))
			loaded <= 1'b1;
		else if (start | keep_going)
			loaded <= 1'b0;
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			shreg          <= sstx_pkg::DUMMY_BYTE;
			SERIAL_OUT_PIN <= 1'b1;
		end else if (start_in) begin
			SERIAL_OUT_PIN <= frame_byte[0];
			shreg          <= {1'b1, frame_byte[7:1]};
		end else if (start_out) begin
			shreg <= frame_byte;
		end else if (fall) begin
			SERIAL_OUT_PIN <= shreg[0];
			shreg          <= {1'b1, shreg[7:1]};
		end else if (refill | early_move) begin
			shreg <= q_rdata;
		end
	end

	// Holding store empty flag: set by every move, cleared by a data write
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN)
			hold_empty <= sstx_pkg::EMPTY_RESET;
		else if (move_evt)
			hold_empty <= 1'b1;
		else if (data_wr)
			hold_empty <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////
	// Level interrupt condition
	wire [2:0] lvl_after = q_level + 3'(q_push & ~q_full) - 3'h1;
	wire [2:0] thr = full_dpx ? {2'h0, txcfg.level[0]} : {1'h0, txcfg.level};
	wire lvl_hit = pop & mode.queue_enable & ((lvl_after == thr)
		| (txcfg.cond & (lvl_after < thr)));
	wire lvl_evt = lvl_hit & mode.irq_enable;

	////////////////////////////////////////////////////////////////////////////
	// Control and status registers
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			mode     <= sstx_pkg::MODE_RESET;
			txcfg    <= sstx_pkg::TXCFG_RESET;
			irq_mask <= 3'h0;
		end else begin
			if (wr_go & sel_mode)
				mode <= sstx_pkg::sstx_mode_t'(AVS_WRITEDATA[5:0]);
			if (wr_go & sel_txcfg) begin
				txcfg.cond  <= AVS_WRITEDATA[sstx_pkg::TXCFG_COND_BIT];
				txcfg.level <= AVS_WRITEDATA[1:0];
			end
			if (wr_go & sel_imask)
				irq_mask <= AVS_WRITEDATA[2:0];
		end
	end

	// Hardware set wins over the software clear in the same cycle
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			rx_overrun  <= 1'b0;
			tx_underrun <= sstx_pkg::UNDERRUN_RESET;
		end else begin
			rx_overrun  <= RX_OVERRUN_EVENT | (rx_overrun & ~data_rd);
			tx_underrun <= underrun | (tx_underrun & ~data_wr);
		end
	end

	wire [2:0] evt_vec  = {lvl_evt, underrun, tx_evt};
	wire [2:0] w1c_vec  = (wr_go & sel_ists) ? AVS_WRITEDATA[2:0] : 3'h0;

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			irq_status         <= 3'h0;
			TRANSMIT_INTERRUPT <= 1'b0;
			UNDERRUN_EVENT     <= 1'b0;
		end else begin
			irq_status         <= evt_vec | (irq_status & ~w1c_vec);
			TRANSMIT_INTERRUPT <= tx_evt;
			UNDERRUN_EVENT     <= underrun;
		end
	end

	assign IRQ = |(irq_status & irq_mask);

	////////////////////////////////////////////////////////////////////////////
	// Read mux; unmapped offsets read zero
	always_comb begin
		read_word = 32'h0000_0000;
		if (sel_data)
			read_word[7:0] = RX_DATA;
		if (sel_mode)
			read_word[6:0] = {hold_empty, mode};
		if (sel_txcfg)
			read_word[sstx_pkg::TXCFG_COND_BIT] = txcfg.cond;
		if (sel_txcfg)
			read_word[1:0] = txcfg.level;
		if (sel_rxst)
			read_word[7:0] = {rx_overrun, 4'h0, RX_OCCUPANCY};
		if (sel_txst)
			read_word[7:0] = {tx_underrun, 4'h0, q_level};
		if (sel_ists)
			read_word[2:0] = irq_status;
		if (sel_imask)
			read_word[2:0] = irq_mask;
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN)
			AVS_READDATA <= 32'h0000_0000;
		else if (AVS_READ & ~ack)
			AVS_READDATA <= read_word;
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking @(posedge CLK); endclocking
	default disable iff (!RESETN);

	AST_CLEAR_EMPTIES: assert property (q_clear |=> q_level == 3'h0)
		else $error("Queue clear left data behind");
	AST_CLEAR_READS_ZERO: assert property (
		AVS_READ & ~ack & sel_txcfg |=> AVS_READDATA[7] == 1'b0)
		else $error("Clear bit read back as one");
	AST_LEVEL_HALF: assert property (
		pop & mode.queue_enable & mode.irq_enable & ~full_dpx
		& (lvl_after == {1'h0, txcfg.level}) |=> irq_status[2])
		else $error("Threshold reach gave no level interrupt");
	AST_LEVEL_FULL: assert property (
		pop & mode.queue_enable & mode.irq_enable & full_dpx & txcfg.level[1]
		& (lvl_after == {2'h0, txcfg.level[0]}) |=> irq_status[2])
		else $error("Full duplex threshold not honoured");
	AST_LEVEL_COND: assert property (
		pop & mode.queue_enable & mode.irq_enable & txcfg.cond
		& (lvl_after < thr) |=> irq_status[2])
		else $error("Unreachable threshold gave no interrupt");
	AST_LEVEL_GATED: assert property (
		~mode.irq_enable & ~irq_status[2] & ~(wr_go & sel_mode) |=> ~irq_status[2])
		else $error("Level interrupt without enable");
	AST_OVERRUN: assert property (
		data_rd & ~RX_OVERRUN_EVENT |=> ~rx_overrun)
		else $error("Overrun flag survived data read");
	AST_UNDERRUN_CLEAR: assert property (
		data_wr & ~underrun |=> ~tx_underrun)
		else $error("Underrun flag survived data write");
	AST_TX_LEVEL: assert property (q_level <= sstx_pkg::CAP_HALF_DPX)
		else $error("Queue level out of range");
	AST_FRAME_LEN: assert property (
		start_out & ~dbuf ##1 (~(wr_go & sel_mode)) [*2] |-> ##[60:64] frame_done)
		else $error("Output frame not eight clocks long");
	AST_STOP_NO_IRQ: assert property (
		frame_done & dbuf & mode.clock_out & ~can_pop |-> ~tx_evt ##1 idle & sclk_o)
		else $error("Clock kept running or interrupt raised");
	AST_MOVE_FLAG: assert property (
		move_evt |=> hold_empty & TRANSMIT_INTERRUPT)
		else $error("Move did not flag or interrupt");
	AST_SINGLE_IRQ: assert property (
		frame_done & ~dbuf |=> TRANSMIT_INTERRUPT)
		else $error("Single buffer frame without interrupt");
	AST_DUMMY: assert property (
		underrun |=> SERIAL_OUT_PIN & tx_underrun & ~idle & (bit_cnt == 3'h0))
		else $error("Underrun did not start dummy frame");
	AST_PULSE: assert property (
		UNDERRUN_EVENT |=> ~UNDERRUN_EVENT)
		else $error("Underrun event longer than one cycle");
endmodule

// ---- pkg/sstx_pkg.sv ----
// Purpose: Shared constants and types for the synchronous serial transmit block
// Assumes: 250 MHz peripheral clock, word-addressed Avalon-MM register port
// Notes:   Offsets are word indices; the byte address is four times the index
package sstx_pkg;
	////////////////////////////////////////////////////////////////////////////
	// Timing
	localparam int         CLK_PERIOD_NS     = 4;
	localparam int         SHIFT_HALF_NS     = 16;
	localparam logic [3:0] SHIFT_HALF_CYCLES = 4'(SHIFT_HALF_NS / CLK_PERIOD_NS);
	localparam logic [2:0] LAST_BIT          = 3'h7;
	////////////////////////////////////////////////////////////////////////////
	// Register offsets (word index)
	localparam logic [2:0] OFS_DATA       = 3'h0;
	localparam logic [2:0] OFS_MODE       = 3'h1;
	localparam logic [2:0] OFS_TXCFG      = 3'h2;
	localparam logic [2:0] OFS_RXST       = 3'h3;
	localparam logic [2:0] OFS_TXST       = 3'h4;
	localparam logic [2:0] OFS_IRQ_STATUS = 3'h5;
	localparam logic [2:0] OFS_IRQ_MASK   = 3'h6;
	////////////////////////////////////////////////////////////////////////////
	// Field positions
	localparam int TXCFG_CLEAR_BIT  = 7;
	localparam int TXCFG_COND_BIT   = 6;
	localparam int STATUS_FLAG_BIT  = 7;
	localparam int IRQ_DONE_BIT     = 0;
	localparam int IRQ_UNDERRUN_BIT = 1;
	localparam int IRQ_LEVEL_BIT    = 2;
	////////////////////////////////////////////////////////////////////////////
	// Reset values and codes
	localparam logic       UNDERRUN_RESET = 1'h1;
	localparam logic       EMPTY_RESET    = 1'h1;
	localparam logic [1:0] DUPLEX_FULL    = 2'h3;
	localparam logic [2:0] CAP_SINGLE     = 3'h1;
	localparam logic [2:0] CAP_FULL_DPX   = 3'h2;
	localparam logic [2:0] CAP_HALF_DPX   = 3'h4;
	localparam logic [7:0] DUMMY_BYTE     = 8'hFF;
	////////////////////////////////////////////////////////////////////////////
	// Types
	typedef struct packed {
		logic       irq_enable;
		logic [1:0] duplex;
		logic       queue_enable;
		logic       double_buffer;
		logic       clock_out;
	} sstx_mode_t;

	typedef struct packed {
		logic       cond;
		logic [1:0] level;
	} sstx_txcfg_t;

	localparam sstx_mode_t  MODE_RESET  = '0;
	localparam sstx_txcfg_t TXCFG_RESET = '0;

	typedef enum logic {ST_IDLE, ST_SHIFT} sstx_state_t;
endpackage

// ---- hw/sstx_sync.sv ----
// Purpose: Two-flop synchroniser for the shift clock pin
// Assumes: Input is asynchronous to clk
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
module sstx_sync (
	input  wire logic clk,
	input  wire logic resetn,
	input  wire logic din,
	output logic      dout
);
	logic meta;

	// Resets to the idle-high level of the pin so no false edge follows reset
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			meta <= 1'b1;
			dout <= 1'b1;
		end else begin
			meta <= din;
			dout <= meta;
		end
	end
endmodule

// ---- hw/sstx_queue.sv ----
// Purpose: Four-entry byte queue with a run-time capacity
// Assumes: Push while full and pop while empty are dropped
// Notes:   Clear wins over push and pop in the same cycle
`timescale 1ns/1ps
module sstx_queue (
	input  wire logic       clk,
	input  wire logic       resetn,
	input  wire logic       push,
	input  wire logic       pop,
	input  wire logic       clear,
	input  wire logic [2:0] cap,
	input  wire logic [7:0] wdata,
	output logic [7:0]      rdata,
	output logic [2:0]      level,
	output logic            empty,
	output logic            full
);
	logic [7:0] mem [4];
	logic [1:0] rd_ptr;
	logic [1:0] wr_ptr;
	wire        do_push = push & ~full;
	wire        do_pop  = pop & ~empty;

	assign full  = level >= cap;
	assign empty = level == 3'h0;
	assign rdata = mem[rd_ptr];

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rd_ptr <= 2'h0;
			wr_ptr <= 2'h0;
			level  <= 3'h0;
		end else if (clear) begin
			rd_ptr <= 2'h0;
			wr_ptr <= 2'h0;
			level  <= 3'h0;
		end else begin
			rd_ptr <= rd_ptr + 2'(do_pop);
			wr_ptr <= wr_ptr + 2'(do_push);
			level  <= level + 3'(do_push) - 3'(do_pop);
		end
	end

	for (genvar i = 0; i < 4; i++) begin : g_entry
		always_ff @(posedge clk or negedge resetn) begin
			if (!resetn)
				mem[i] <= 8'h00;
			else if (do_push & ~clear & (wr_ptr == 2'(i)))
				mem[i] <= wdata;
		end
	end
endmodule

// ---- sim/sstx_peer.sv ----
// Purpose: Serial peer that samples the data line and makes the shift clock
// Assumes: Data sampled on rising shift clock edges, LSB first
// Notes:   Own clock idles high and stands still between frames
`timescale 1ns/1ps
module sstx_peer (
	input  wire logic  resetn,
	input  wire logic  pin,
	input  wire logic  sdata,
	input  wire logic  go,
	output logic       clk_in,
	output logic [7:0] rx_byte,
	output logic       got
);
	int n = 0;
	initial begin
		clk_in = 1'b1;
		got = 1'b0;
		rx_byte = 8'h00;
	end
	////////////////////////////////////////////////////////////////////////////
	// Offset puts every peer clock edge 3 ns after a rising block clock edge
	always @(posedge go) begin
		#3;
		repeat (8) begin
			clk_in = 1'b0;
			#16;
			clk_in = 1'b1;
			#16;
		end
	end
	////////////////////////////////////////////////////////////////////////////
	// Reset guard stops the pin settling at time zero from counting as a bit
	always @(posedge pin) begin
		if (resetn) begin
			rx_byte = {sdata, rx_byte[7:1]};
			n = n + 1;
			if (n == 8) begin
				n = 0;
				got = 1'b1;
				#2 got = 1'b0;
			end
		end
	end
endmodule

// ---- sim/testbench.sv ----
// Purpose: Self-checking bench for the serial transmit block
// Assumes: Register offsets and codes from the shared package
// Notes:   Serial bytes are checked by a monitor against a queue of notes
`timescale 1ns/1ps
module testbench;
	logic        CLK = 1'b0;
	logic        RESETN = 1'b0;
	logic [2:0]  addr = 3'h0;
	logic        rd_en = 1'b0;
	logic        wr_en = 1'b0;
	logic [31:0] wdata = 32'h0000_0000;
	logic [31:0] rdata, v;
	logic        waitreq, sclk_out, sclk_oe, sout, rx_read, tx_irq, urun, irq;
	logic [2:0]  rx_occ = 3'h0;
	logic        rx_ovr = 1'b0;
	logic [7:0]  rx_dat = 8'h00;
	logic        go = 1'b0;
	logic        peer_clk, got;
	logic [7:0]  peer_byte, b;
	wire         pin = sclk_oe ? sclk_out : peer_clk;
	int          fails = 0, check_count = 0, tx_n = 0, ur_n = 0, rd_n = 0;
	logic [7:0]  exp_q[$];
	////////////////////////////////////////////////////////////////////////////
	sstx_top sstx_top_inst (
		.CLK(CLK), .RESETN(RESETN), .AVS_ADDRESS(addr), .AVS_READ(rd_en),
		.AVS_WRITE(wr_en), .AVS_WRITEDATA(wdata), .AVS_READDATA(rdata),
		.AVS_WAITREQUEST(waitreq), .SHIFT_CLOCK_PIN_IN(pin),
		.SHIFT_CLOCK_PIN_OUT(sclk_out), .SHIFT_CLOCK_PIN_OE(sclk_oe),
		.SERIAL_OUT_PIN(sout), .RX_OCCUPANCY(rx_occ), .RX_OVERRUN_EVENT(rx_ovr),
		.RX_DATA(rx_dat), .RX_DATA_READ(rx_read), .TRANSMIT_INTERRUPT(tx_irq),
		.UNDERRUN_EVENT(urun), .IRQ(irq));
	sstx_peer sstx_peer_inst (.resetn(RESETN), .pin(pin), .sdata(sout), .go(go),
		.clk_in(peer_clk), .rx_byte(peer_byte), .got(got));
	initial forever #2 CLK = ~CLK;
	////////////////////////////////////////////////////////////////////////////
	task automatic print_verdict();
		$display("mismatches %0d, comparisons %0d", fails, check_count);
		if (fails == 0 && check_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	// Request held until waitrequest is seen low at a rising edge; the watchdog ends a hang
	task automatic bus(input logic w, input logic [2:0] a, input logic [31:0] d);
		@(posedge CLK);
		addr <= a;
		wdata <= d;
		wr_en <= w;
		rd_en <= !w;
		do begin
			@(posedge CLK);
		end while (waitreq !== 1'b0);
		v = rdata;
		wr_en <= 1'b0;
		rd_en <= 1'b0;
	endtask
	task automatic rdc(input logic [2:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0000_0000);
		chk(v, e);
	endtask
	task automatic wb();
		b = 8'($urandom);
		exp_q.push_back(b);
		bus(1'b1, sstx_pkg::OFS_DATA, 32'(b));
	endtask
	task automatic wq();
		int k;
		k = 0;
		while (exp_q.size() != 0 && k < 2000) begin
			@(posedge CLK);
			k++;
		end
		if (k >= 2000) fails++;
		repeat (10) @(posedge CLK);
	endtask
	// One peer frame: waits for its byte only, later notes may still be queued
	task automatic fr();
		int n0;
		n0 = exp_q.size();
		@(posedge CLK);
		go <= 1'b1;
		@(posedge CLK);
		go <= 1'b0;
		while (exp_q.size() >= n0) @(posedge CLK);
		repeat (10) @(posedge CLK);
	endtask
	////////////////////////////////////////////////////////////////////////////
	always @(posedge got) begin
		if (exp_q.size() == 0) begin
			fails++;
			$display("wrong value at %0t: unexpected byte", $time);
		end else chk(32'(peer_byte), 32'(exp_q.pop_front()));
	end
	always @(posedge CLK) begin
		if (tx_irq === 1'b1) tx_n++;
		if (urun === 1'b1) ur_n++;
		if (rx_read === 1'b1) rd_n++;
	end
	initial begin
		#200000;
		fails++;
		print_verdict();
	end
	////////////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(32'h3198_bcb5));
		repeat (12) @(posedge CLK);
		RESETN <= 1'b1;
		rx_occ <= 3'($urandom_range(4));
		rx_dat <= 8'($urandom);
		rdc(sstx_pkg::OFS_TXST, 32'h80);
		rdc(sstx_pkg::OFS_TXCFG, 32'h0);
		rdc(sstx_pkg::OFS_MODE, 32'h40);
		bus(1'b1, 3'h7, 32'hFF);
		rdc(3'h7, 32'h0);
		// Clock driven out, single buffer
		bus(1'b1, sstx_pkg::OFS_MODE, 32'h1);
		wb();
		wq();
		chk(sclk_oe, 32'h1);
		chk(tx_n, 32'h1);
		rdc(sstx_pkg::OFS_TXST, 32'h0);
		rdc(sstx_pkg::OFS_IRQ_STATUS, 32'h1);
		chk(irq, 32'h0);
		bus(1'b1, sstx_pkg::OFS_IRQ_MASK, 32'h7);
		#1 chk(irq, 32'h1);
		bus(1'b1, sstx_pkg::OFS_IRQ_STATUS, 32'h1);
		#1 chk(irq, 32'h0);
		// Clock driven out, double buffer, back-to-back writes
		bus(1'b1, sstx_pkg::OFS_MODE, 32'h3);
		wb();
		wb();
		wq();
		chk(tx_n, 32'h3);
		rdc(sstx_pkg::OFS_MODE, 32'h43);
		repeat (40) @(posedge CLK) chk(sclk_out, 32'h1);
		// Clock from the peer, single buffer; byte written before the frame
		bus(1'b1, sstx_pkg::OFS_MODE, 32'h0);
		wb();
		fr();
		chk(sclk_oe, 32'h0);
		chk(tx_n, 32'h4);
		// Clock from the peer, queue of four, threshold three bytes
		bus(1'b1, sstx_pkg::OFS_IRQ_STATUS, 32'h7);
		bus(1'b1, sstx_pkg::OFS_TXCFG, 32'h3);
		bus(1'b1, sstx_pkg::OFS_MODE, 32'h24);
		repeat (5) wb();
		bus(1'b1, sstx_pkg::OFS_DATA, 32'hAA);
		rdc(sstx_pkg::OFS_TXST, 32'h4);
		rdc(sstx_pkg::OFS_IRQ_STATUS, 32'h1);
		repeat (5) fr();
		chk(tx_n, 32'h9);
		rdc(sstx_pkg::OFS_IRQ_STATUS, 32'h5);
		exp_q.push_back(sstx_pkg::DUMMY_BYTE);
		fr();
		chk(ur_n, 32'h1);
		rdc(sstx_pkg::OFS_TXST, 32'h80);
		rdc(sstx_pkg::OFS_IRQ_STATUS, 32'h7);
		// Receive status from the neighbour
		rx_ovr <= 1'b1;
		@(posedge CLK) rx_ovr <= 1'b0;
		rdc(sstx_pkg::OFS_RXST, {24'h0, 5'h10, rx_occ});
		rdc(sstx_pkg::OFS_DATA, 32'(rx_dat));
		rdc(sstx_pkg::OFS_RXST, 32'(rx_occ));
		chk(rd_n, 32'h1);
		// Full duplex: threshold one byte with the condition bit, then clear
		bus(1'b1, sstx_pkg::OFS_IRQ_STATUS, 32'h7);
		bus(1'b1, sstx_pkg::OFS_TXCFG, 32'h43);
		bus(1'b1, sstx_pkg::OFS_MODE, 32'h3C);
		wb();
		rdc(sstx_pkg::OFS_IRQ_STATUS, 32'h5);
		bus(1'b1, sstx_pkg::OFS_IRQ_STATUS, 32'h7);
		repeat (2) wb();
		repeat (3) fr();
		rdc(sstx_pkg::OFS_IRQ_STATUS, 32'h5);
		repeat (4) wb();
		rdc(sstx_pkg::OFS_TXST, 32'h2);
		bus(1'b1, sstx_pkg::OFS_TXCFG, 32'h83);
		rdc(sstx_pkg::OFS_TXCFG, 32'h3);
		rdc(sstx_pkg::OFS_TXST, 32'h0);
		exp_q.delete();
		print_verdict();
	end
endmodule
